// file: rtl/pwmds_top.sv
/*
  PWM output stage: half-bridge dead-band, auto-shutdown status with
  auto-restart, and single-output pulse steering onto four pins, with
  an AHB-Lite register slave and one level interrupt.
  Assumes pwm_raw, period_start, port_data and port_dir come from logic
  on sys_clk; shutdown_cause is an asynchronous pin.
*/
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
// Notes on behaviour
// - Half-bridge delays only inactive-to-active edges.
// - Dead-band from low seven control bits.
// - Count equals instruction cycles of delay.
// - Auto-restart clears shutdown status by hardware.
// - Without auto-restart, software clears shutdown status.
// - Steering only in single-output PWM mode.
// - One waveform onto any pin combination.
// - Enable bit routes waveform, else port.
// - Polarity bits apply to steered pins.
// - Sync clear: steering changes right after write.
// - Sync set: steering changes at period start.
// - Shutdown forces only enabled pins.
// - Steering bits 7:5 read zero; resets 0x01.
// - Status stays set while cause persists.
// - Output resumes at next period start.
`default_nettype none

module pwmds_top #(
  parameter int DC_W = 7                     // Dead-band count width
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,           // Low freezes all state
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        pwm_raw,          // Modulated waveform, active high
  input  wire logic        period_start,     // Pulse on first cycle of a period
  input  wire logic        shutdown_cause,   // Asynchronous shutdown level
  input  wire logic [3:0]  port_data,        // Port latch values, D..A
  input  wire logic [3:0]  port_dir,         // Pin direction bits, 0 = output
  output logic             pwm_out_a,
  output logic             pwm_out_b,
  output logic             pwm_out_c,
  output logic             pwm_out_d,
  output logic [3:0]       pin_oe_n,         // Low while the pin is driven
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        dph_wr_reg, dph_wr_next;      // Write data phase pending
  logic [7:0]  dph_addr_reg, dph_addr_next;  // Offset of pending write
  logic [31:0] hrdata_reg, hrdata_next;      // Read data for data phase
  logic        hreadyout_reg;                // Zero wait states
  logic        hresp_reg;                    // Always OKAY
  logic        addr_ph;                      // Valid word address phase

  logic [7:0]  rstdb_reg, rstdb_next;        // Restart enable, dead-band count
  logic [4:0]  steer_reg, steer_next;        // Steering as software wrote it
  logic [3:0]  steer_eff_reg, steer_eff_next; // Steering seen by the pins
  logic        pend_reg, pend_next;          // Steering waits for period
  logic [7:0]  mode_reg, mode_next;          // Bridge and cap/comp mode
  logic [3:0]  shst_reg, shst_next;          // Shutdown pin states AC, BD
  logic        status_reg, status_next;      // Shutdown event status
  logic        live_reg, live_next;          // PWM running after restart
  logic [2:0]  ist_reg, ist_next;            // Sticky events
  logic [2:0]  imask_reg, imask_next;        // Event mask
  logic [2:0]  ev;                           // Events this cycle
  logic        sd_meta_reg, sd_sync_reg;     // Shutdown pin synchroniser

  logic [3:0]  pin_reg, pin_next;            // Pin levels D..A
  logic [3:0]  oe_n_reg, oe_n_next;          // Pin enables D..A
  logic        irq_reg, irq_next;

  logic        wr_rstdb, wr_steer, wr_mode, wr_shut, wr_ist, wr_imask;
  logic        mode_single, mode_half;
  logic [1:0]  sched;                        // Half-bridge scheduled actives
  logic [1:0]  db_act;                       // After dead-band
  logic [1:0]  pol;                          // Active-low select AC, BD
  logic [DC_W-1:0] dband_cnt;

  // low seven bits give the count
  assign dband_cnt = rstdb_reg[DC_W-1:0];
  assign pol       = mode_reg[1:0];

  assign mode_single = (mode_reg[3:2] == pwmds_pkg::CCP_PWM) &&
                       (mode_reg[7:6] == pwmds_pkg::BRIDGE_SINGLE);
  assign mode_half   = (mode_reg[3:2] == pwmds_pkg::CCP_PWM) &&
                       (mode_reg[7:6] == pwmds_pkg::BRIDGE_HALF);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Only whole-word transfers are taken; others complete with no effect
  assign addr_ph = hsel && htrans[1] && hready && (hsize == 3'h2);

  // Write strobes in the data phase
  assign wr_rstdb = dph_wr_reg && (dph_addr_reg == pwmds_pkg::OFS_RSTDB);
  assign wr_steer = dph_wr_reg && (dph_addr_reg == pwmds_pkg::OFS_STEER);
  assign wr_mode  = dph_wr_reg && (dph_addr_reg == pwmds_pkg::OFS_MODE);
  assign wr_shut  = dph_wr_reg && (dph_addr_reg == pwmds_pkg::OFS_SHUT);
  assign wr_ist   = dph_wr_reg && (dph_addr_reg == pwmds_pkg::OFS_ISTAT);
  assign wr_imask = dph_wr_reg && (dph_addr_reg == pwmds_pkg::OFS_IMASK);

  // Read data is fetched in the address phase so it stands from a flop
  always_comb begin
    dph_wr_next   = addr_ph && hwrite;
    dph_addr_next = addr_ph ? haddr[7:0] : dph_addr_reg;
    hrdata_next   = 32'h0000_0000;
    if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        pwmds_pkg::OFS_RSTDB: hrdata_next = {24'h00_0000, rstdb_reg};
        pwmds_pkg::OFS_STEER: hrdata_next = {27'h000_0000, steer_reg};
        pwmds_pkg::OFS_MODE:  hrdata_next = {24'h00_0000, mode_reg};
        pwmds_pkg::OFS_SHUT:  hrdata_next = {24'h00_0000, status_reg, 3'h0, shst_reg};
        pwmds_pkg::OFS_ISTAT: hrdata_next = {29'h0000_0000, ist_reg};
        pwmds_pkg::OFS_IMASK: hrdata_next = {29'h0000_0000, imask_reg};
        // Unmapped offsets read zero and answer OKAY
        default:              hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dph_wr_reg    <= 1'b0;
      dph_addr_reg  <= 8'h00;
      hrdata_reg    <= 32'h0000_0000;
      hreadyout_reg <= 1'b1;
      hresp_reg     <= 1'b0;
    end else if (clk_en) begin
      dph_wr_reg    <= dph_wr_next;
      dph_addr_reg  <= dph_addr_next;
      hrdata_reg    <= hrdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sd_meta_reg <= 1'b0;
      sd_sync_reg <= 1'b0;
    end else if (clk_en) begin
      sd_meta_reg <= shutdown_cause;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Control registers, shutdown and steering
  // ----------------------------------------------------------------
  always_comb begin
    rstdb_next = wr_rstdb ? hwdata[7:0] : rstdb_reg;
    mode_next  = wr_mode ? (hwdata[7:0] & pwmds_pkg::MODE_MASK) : mode_reg;
    shst_next  = wr_shut ? hwdata[3:0] : shst_reg;
    imask_next = wr_imask ? hwdata[2:0] : imask_reg;
    steer_next = wr_steer ? hwdata[4:0] : steer_reg;

    // a present cause keeps status set and blocks the write
    if (sd_sync_reg) begin
      status_next = 1'b1;
    end else if (wr_shut) begin
      // software sets or clears the status
      status_next = hwdata[pwmds_pkg::STATUS_BIT];
    end else if (rstdb_reg[pwmds_pkg::RESTART_BIT]) begin
      status_next = 1'b0;
    end else begin
      status_next = status_reg;
    end

    // resume only on a period boundary
    if (status_reg) begin
      live_next = 1'b0;
    end else if (period_start) begin
      live_next = 1'b1;
    end else begin
      live_next = live_reg;
    end

    steer_eff_next = steer_eff_reg;
    pend_next      = pend_reg;
    if (wr_steer && !hwdata[pwmds_pkg::SYNC_BIT]) begin
      steer_eff_next = hwdata[3:0];
      pend_next      = 1'b0;
    end else if (wr_steer) begin
      pend_next = 1'b1;
    end else if (pend_reg && period_start) begin
      // apply at the start of the next period
      steer_eff_next = steer_reg[3:0];
      pend_next      = 1'b0;
    end

    // Events; a set in the cycle of a clear wins
    ev[pwmds_pkg::EV_SHUT]    = status_next && !status_reg;
    ev[pwmds_pkg::EV_RESTART] = live_next && !live_reg;
    ev[pwmds_pkg::EV_STEER]   = (steer_eff_next != steer_eff_reg);
    ist_next = (ist_reg & ~(wr_ist ? hwdata[2:0] : 3'h0)) | ev;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rstdb_reg     <= pwmds_pkg::RST_RSTDB;
      steer_reg     <= pwmds_pkg::RST_STEER;
      steer_eff_reg <= pwmds_pkg::RST_STEER[3:0];
      pend_reg      <= 1'b0;
      mode_reg      <= pwmds_pkg::RST_MODE;
      shst_reg      <= pwmds_pkg::RST_SHST;
      status_reg    <= 1'b0;
      live_reg      <= 1'b0;
      ist_reg       <= pwmds_pkg::RST_IRQ;
      imask_reg     <= pwmds_pkg::RST_IRQ;
    end else if (clk_en) begin
      rstdb_reg     <= rstdb_next;
      steer_reg     <= steer_next;
      steer_eff_reg <= steer_eff_next;
      pend_reg      <= pend_next;
      mode_reg      <= mode_next;
      shst_reg      <= shst_next;
      status_reg    <= status_next;
      live_reg      <= live_next;
      ist_reg       <= ist_next;
      imask_reg     <= imask_next;
    end
  end

  // ----------------------------------------------------------------
  // Half-bridge dead-band channels
  // ----------------------------------------------------------------
  // A active on the high phase, B on the low phase
  assign sched[0] = mode_half && live_reg && pwm_raw;
  assign sched[1] = mode_half && live_reg && !pwm_raw;

  for (genvar g = 0; g < 2; g++) begin : g_db
    pwmds_dband #(
      .DC_W      (DC_W),
      .CNT_W     (DC_W + 3)
    ) u_dband (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .clk_en    (clk_en),
      .sched     (sched[g]),
      .delay_cnt (dband_cnt),
      .act       (db_act[g])
    );
  end

  // ----------------------------------------------------------------
  // Pin multiplexer
  // ----------------------------------------------------------------
  // Shutdown is taken one cycle late; synchronous forcing keeps pins glitch free
  always_comb begin
    logic       sel;                         // Pin carries the PWM
    logic       act;                         // Active before polarity
    logic       pol_low;                     // Pin is active low
    logic [1:0] sst;                         // Shutdown state of the pair
    sel     = 1'b0;
    act     = 1'b0;
    pol_low = 1'b0;
    sst     = 2'h0;
    for (int i = 0; i < 4; i++) begin
      // each pin chosen on its own
      sel     = mode_single ? steer_eff_reg[i] : (mode_half && (i < 2));
      act     = mode_single ? (live_reg && pwm_raw) : db_act[i % 2];
      pol_low = ((i % 2) == 0) ? pol[1] : pol[0];
      sst     = ((i % 2) == 0) ? shst_reg[3:2] : shst_reg[1:0];
      oe_n_next[i] = port_dir[i];
      if (!sel) begin
        // unsteered pin is a port pin
        pin_next[i] = port_data[i];
      end else if (status_reg) begin
        // only enabled pins take the shutdown state
        pin_next[i] = sst[1] ? 1'b0 : sst[0];
        if (sst[1]) begin
          oe_n_next[i] = 1'b1;
        end
      end else begin
        // polarity applied on every steered pin
        pin_next[i] = act ^ pol_low;
      end
    end
    irq_next = |(ist_reg & imask_reg);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_reg  <= 4'h0;
      oe_n_reg <= 4'hF;
      irq_reg  <= 1'b0;
    end else if (clk_en) begin
      pin_reg  <= pin_next;
      oe_n_reg <= oe_n_next;
      irq_reg  <= irq_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hresp     = hresp_reg;
  assign hrdata    = hrdata_reg;
  assign pwm_out_a = pin_reg[0];
  assign pwm_out_b = pin_reg[1];
  assign pwm_out_c = pin_reg[2];
  assign pwm_out_d = pin_reg[3];
  assign pin_oe_n  = oe_n_reg;
  assign irq       = irq_reg;

  // ----------------------------------------------------------------
  // Assertions and cover points
  // ----------------------------------------------------------------
  logic [9:0]      sa_cnt;                   // Cycles channel A was scheduled
  logic [DC_W-1:0] sa_dc;                    // Count loaded when the wait began
  // Count captured at the scheduled rise, so a later rewrite cannot confuse the check
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sa_cnt <= 10'h000;
      sa_dc  <= '0;
    end else if (clk_en) begin
      sa_cnt <= !sched[0] ? 10'h000 : ((sa_cnt == 10'h3FF) ? sa_cnt : sa_cnt + 10'h001);
      if (sa_cnt == 10'h000) begin
        sa_dc <= dband_cnt;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_db_rise_delay:
  assert property ($rose(db_act[0]) |->
                   sa_cnt == 10'(sa_dc) * 10'(pwmds_pkg::TCY_CLKS) + 10'h001)
    else $error("dead-band rise delay wrong");

  chk_db_fall_now:
  assert property (clk_en && db_act[0] && !sched[0] |=> !db_act[0])
    else $error("dead-band fall delayed");

  chk_status_cause:
  assert property (clk_en && sd_sync_reg |=> status_reg)
    else $error("status clear while cause present");

  chk_status_hold:
  assert property (clk_en && status_reg && !rstdb_reg[7] && !wr_shut |=> status_reg)
    else $error("status cleared without software");

  chk_auto_clear:
  assert property (clk_en && status_reg && rstdb_reg[7] && !sd_sync_reg && !wr_shut
                   |=> !status_reg)
    else $error("auto-restart did not clear status");

  chk_steer_now:
  assert property (clk_en && wr_steer && !hwdata[4] |=> steer_eff_reg == $past(hwdata[3:0]))
    else $error("immediate steering not applied");

  chk_steer_sync:
  assert property ($changed(steer_eff_reg) |->
                   $past(period_start) || $past(wr_steer && !hwdata[4]))
    else $error("steering changed off a boundary");

  chk_resume_period:
  assert property ($rose(live_reg) |-> $past(period_start) && !$past(status_reg))
    else $error("output resumed mid-period");

  chk_port_pins:
  assert property (clk_en && !mode_single && !mode_half ##1 clk_en |->
                   pin_reg == $past(port_data))
    else $error("port pins not passed through");

  chk_shut_force:
  assert property (clk_en && status_reg && mode_single && steer_eff_reg[0] &&
                   !shst_reg[3] |=> pwm_out_a == $past(shst_reg[2]))
    else $error("enabled pin not forced on shutdown");

  cov_db_delay: cover property ($rose(db_act[0]) && dband_cnt != '0);
  cov_sync_apply: cover property (pend_reg && period_start && clk_en);
  cov_auto_restart: cover property ($fell(status_reg) && rstdb_reg[7]);

endmodule

`default_nettype wire

// file: rtl/pwmds_pkg.sv
/*
  Shared constants for the PWM dead-band and steering output stage.
  Holds register offsets, field positions, reset values, modes and the
  dead-band state encoding. Assumes a single 125 MHz clock domain.
*/
`default_nettype none

package pwmds_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets (low address bits, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RSTDB = 8'h00;  // Restart and dead-band control
  localparam logic [7:0] OFS_STEER = 8'h04;  // Output steering control
  localparam logic [7:0] OFS_MODE  = 8'h08;  // Capture/compare and bridge mode
  localparam logic [7:0] OFS_SHUT  = 8'h0C;  // Shutdown status and pin states
  localparam logic [7:0] OFS_ISTAT = 8'h10;  // Sticky event status, write 1 to clear
  localparam logic [7:0] OFS_IMASK = 8'h14;  // Event mask, 1 lets the event through

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RSTDB = 8'h00;
  localparam logic [4:0] RST_STEER = 5'h01;  // Pin A steered, others port
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [3:0] RST_SHST  = 4'h0;
  localparam logic [2:0] RST_IRQ   = 3'h0;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int RESTART_BIT = 7;            // Auto-restart enable
  localparam int SYNC_BIT    = 4;            // Steering sync select
  localparam int STATUS_BIT  = 7;            // Shutdown event status
  localparam logic [7:0] MODE_MASK = 8'hCF;  // Bridge mode 7:6, cap/comp mode 3:0

  // Mode codes
  localparam logic [1:0] CCP_PWM       = 2'h3;  // Cap/comp high bits for PWM
  localparam logic [1:0] BRIDGE_SINGLE = 2'h0;
  localparam logic [1:0] BRIDGE_HALF   = 2'h2;

  // Event bits of the sticky status
  localparam int EV_SHUT    = 0;             // Shutdown entered
  localparam int EV_RESTART = 1;             // Outputs resumed
  localparam int EV_STEER   = 2;             // Steering applied to pins

  // ----------------------------------------------------------------
  // Timing: one instruction cycle is four oscillator periods
  // ----------------------------------------------------------------
  localparam int TCY_TOSC = 4;               // Instruction cycle in Tosc
  localparam int TOSC_NS  = 8;               // Oscillator period in ns
  localparam int CLK_NS   = 8;               // Period of sys_clk in ns
  localparam int TCY_CLKS = (TCY_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;

  // Dead-band delay state, Gray along idle -> wait -> on
  typedef enum logic [1:0] {
    DB_IDLE = 2'b00,
    DB_WAIT = 2'b01,
    DB_ON   = 2'b11
  } pwmds_db_state_t;

endpackage

`default_nettype wire

// file: rtl/pwmds_dband.sv
/*
  One dead-band delay channel: delays the inactive-to-active edge of a
  scheduled output by a programmed number of instruction cycles and
  passes the active-to-inactive edge through at once.
  Assumes sched comes from logic on sys_clk.
*/
`default_nettype none

module pwmds_dband #(
  parameter int DC_W  = 7,                   // Width of the delay count
  parameter int CNT_W = 10                   // Width of the clock counter
) (
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic             sched,       // Output scheduled active
  input  wire logic [DC_W-1:0]  delay_cnt,   // Delay in instruction cycles
  output logic                  act          // Delayed active level
);

  pwmds_pkg::pwmds_db_state_t st_reg;        // Channel state
  pwmds_pkg::pwmds_db_state_t st_next;
  logic [CNT_W-1:0]           cnt_reg;       // Clocks left to wait
  logic [CNT_W-1:0]           cnt_next;
  logic [CNT_W-1:0]           load_val;      // First count of a wait

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    load_val = CNT_W'(CNT_W'(delay_cnt) * CNT_W'(pwmds_pkg::TCY_CLKS) - CNT_W'(1));
    st_next  = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      // Each new scheduled rise restarts the count
      pwmds_pkg::DB_IDLE: begin
        if (sched) begin
          if (delay_cnt == '0) begin
            st_next = pwmds_pkg::DB_ON;
          end else begin
            st_next  = pwmds_pkg::DB_WAIT;
            cnt_next = load_val;
          end
        end
      end
      pwmds_pkg::DB_WAIT: begin
        if (!sched) begin
          st_next = pwmds_pkg::DB_IDLE;
        end else if (cnt_reg == '0) begin
          st_next = pwmds_pkg::DB_ON;
        end else begin
          cnt_next = CNT_W'(cnt_reg - CNT_W'(1));
        end
      end
      pwmds_pkg::DB_ON: begin
        if (!sched) begin
          st_next = pwmds_pkg::DB_IDLE;
        end
      end
      // Unused code 10 falls back to idle
      default: begin
        st_next = pwmds_pkg::DB_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers, frozen while clk_en is low
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg  <= pwmds_pkg::DB_IDLE;
      cnt_reg <= '0;
    end else if (clk_en) begin
      st_reg  <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  assign act = (st_reg == pwmds_pkg::DB_ON);

endmodule

`default_nettype wire

// file: dv/pwmds_bridge.sv
/*
  Half-bridge switch model on the far side of the pins.
  Assumes the bench commands its overcurrent trip.
*/
`default_nettype none
module pwmds_bridge (
  input  wire logic trip,
  output logic      fault
);
  timeunit 1ns;
  timeprecision 1ns;
  // Overcurrent level held for as long as the trip lasts
  assign fault = trip;
endmodule
`default_nettype wire

// file: dv/pwmds_top_tb.sv
/*
  Self-checking bench for the PWM output stage, one task per scenario.
  Assumes one 125 MHz clock and zero-wait bus answers.
*/
`default_nettype none
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %0t value differs", $time); end end
module pwmds_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 0, rstn = 0, hwrite = 0, pwm_raw = 0, period_start = 0, trip = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdat, hrdata;
  logic [3:0]  port_data = 4'h0, port_dir = 4'h0, oe_n;
  logic        hreadyout, hresp, irq, a, b, c, d, fault;
  int          num_errors = 0, checks_done = 0, t0, t1;
  pwmds_top dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pwm_raw(pwm_raw),
    .period_start(period_start), .shutdown_cause(fault), .port_data(port_data),
    .port_dir(port_dir), .pwm_out_a(a), .pwm_out_b(b), .pwm_out_c(c), .pwm_out_d(d),
    .pin_oe_n(oe_n), .irq(irq));
  pwmds_bridge bridge (.trip(trip), .fault(fault));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Single word transfer; waits on hready, never a fixed count
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h00_0000, ad};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask
  task automatic chk(input logic [7:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h0000_0000);
    `CK(rdat, e)
    `CK(hresp, 1'b0)
  endtask
  // Period boundary pulse, then let the pins settle
  task automatic per();
    period_start <= 1'b1;
    @(posedge sys_clk) period_start <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic t_regs();
    chk(8'h00, 32'h0000_0000);
    chk(8'h04, 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0000_00FF);
    chk(8'h00, 32'h0000_00FF);
    bus(1'b1, 8'h04, 32'h0000_00FF);
    chk(8'h04, 32'h0000_001F);
    bus(1'b1, 8'h40, 32'h0000_00FF);
    chk(8'h40, 32'h0000_0000);
  endtask
  task automatic t_steer();
    logic [3:0] s[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'hF};
    bus(1'b1, 8'h08, 32'h0000_000C);
    pwm_raw <= 1'b1;
    per();
    foreach (s[i]) begin
      bus(1'b1, 8'h04, {28'h000_0000, s[i]});
      repeat (3) @(posedge sys_clk);
      `CK({d, c, b, a}, s[i])
    end
    bus(1'b1, 8'h08, 32'h0000_000F);
    repeat (3) @(posedge sys_clk);
    `CK({d, c, b, a}, 4'h0)
    pwm_raw <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CK({d, c, b, a}, 4'hF)
    bus(1'b1, 8'h08, 32'h0000_0007);
    repeat (3) @(posedge sys_clk);
    `CK({d, c, b, a}, 4'h0)
  endtask
  task automatic t_sync();
    bus(1'b1, 8'h08, 32'h0000_000C);
    pwm_raw <= 1'b1;
    bus(1'b1, 8'h04, 32'h0000_0011);
    repeat (3) @(posedge sys_clk);
    `CK({d, c, b, a}, 4'hF)
    per();
    `CK({d, c, b, a}, 4'h1)
    bus(1'b1, 8'h04, 32'h0000_0002);
    repeat (2) @(posedge sys_clk);
    `CK({d, c, b, a}, 4'h2)
  endtask
  // Edges from the raw rise to pin A; B must drop at once
  task automatic dband(input logic [6:0] n, output int t);
    bus(1'b1, 8'h00, {25'h000_0000, n});
    pwm_raw <= 1'b0;
    repeat (560) @(posedge sys_clk);
    pwm_raw <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CK(b, 1'b0)
    t = 3;
    while (a !== 1'b1 && t < 700) begin
      @(posedge sys_clk);
      t++;
    end
  endtask
  task automatic t_db();
    bus(1'b1, 8'h08, 32'h0000_008C);
    per();
    dband(7'h00, t0);
    dband(7'h03, t1);
    `CK(t1 - t0, 12)
    dband(7'h7F, t1);
    `CK(t1 - t0, 508)
  endtask
  // Shutdown with software restart, then with auto-restart
  task automatic t_shut();
    bus(1'b1, 8'h00, 32'h0000_0000);
    bus(1'b1, 8'h08, 32'h0000_000C);
    bus(1'b1, 8'h04, 32'h0000_0003);
    bus(1'b1, 8'h0C, 32'h0000_0004);
    bus(1'b1, 8'h14, 32'h0000_0001);
    port_data <= 4'hC;
    port_dir  <= 4'h8;
    pwm_raw <= 1'b0;
    per();
    trip <= 1'b1;
    repeat (8) @(posedge sys_clk);
    `CK({d, c, b, a, irq}, 5'b11011)
    `CK(oe_n, 4'h8)
    trip <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(8'h0C, 32'h0000_0084);
    bus(1'b1, 8'h0C, 32'h0000_0004);
    bus(1'b1, 8'h10, 32'h0000_0007);
    pwm_raw <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CK({b, a}, 2'b00)
    per();
    `CK({d, c, b, a, irq}, 5'b11110)
    bus(1'b1, 8'h00, 32'h0000_0080);
    trip <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(8'h0C, 32'h0000_0084);
    trip <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk(8'h0C, 32'h0000_0004);
    chk(8'h10, 32'h0000_0003);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #200_000;
    num_errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_steer();
    t_sync();
    t_db();
    t_shut();
    test_done();
  end
endmodule
`default_nettype wire
